/* common/rfd_pkg.sv */
/*
 * rfd_pkg: constants, carrier types and state encoding for the remote frame decoder.
 * Assumes a single 10 MHz system clock and a synchronous serial input.
 */
`default_nettype none

package rfd_pkg;

	// ============================================================
	// frame layout
	localparam int ADDR_DIGITS     = 10;
	localparam int DATA_BITS       = 8;
	localparam int CELLS_PER_DIGIT = 2;
	localparam int ADDR_CELLS      = ADDR_DIGITS * CELLS_PER_DIGIT;
	localparam int FRAME_CELLS     = ADDR_CELLS + DATA_BITS;
	localparam int IDX_W           = $clog2(FRAME_CELLS);
	localparam logic [IDX_W-1:0] FRAME_LAST = IDX_W'(FRAME_CELLS - 1);

	// ============================================================
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int CELL_NS       = 100_000;
	localparam int GAP_NS        = 300_000;
	localparam int STOP_NS       = 400_000;
	localparam int CNT_W         = 12;
	localparam logic [CNT_W-1:0] CELL_CYC   = CNT_W'(CELL_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] CELL_LAST  = CNT_W'(CELL_NS / CLK_PERIOD_NS - 1);
	localparam logic [CNT_W-1:0] SAMPLE_CYC = CNT_W'(CELL_NS / CLK_PERIOD_NS / 2);
	localparam logic [CNT_W-1:0] GAP_CYC    =
		CNT_W'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] STOP_CYC   =
		CNT_W'((STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ============================================================
	// address digits
	typedef logic [1:0] rfd_trit_t;
	localparam rfd_trit_t TRIT_LOW   = 2'h0;
	localparam rfd_trit_t TRIT_HIGH  = 2'h1;
	localparam rfd_trit_t TRIT_FLOAT = 2'h2;
	localparam rfd_trit_t TRIT_BAD   = 2'h3;
	localparam logic [1:0] PAIR_LOW   = 2'h0;
	localparam logic [1:0] PAIR_HIGH  = 2'h3;
	localparam logic [1:0] PAIR_FLOAT = 2'h1;
	typedef rfd_trit_t [ADDR_DIGITS-1:0] rfd_match_t;

	typedef struct packed {
		logic [ADDR_CELLS-1:0] addr_cells;
		logic [DATA_BITS-1:0]  data;
	} rfd_frame_t;

	// ============================================================
	// register port
	localparam int REG_AW = 4;
	typedef struct packed {
		logic [REG_AW-1:0] addr;
		logic [31:0]       wdata;
		logic              wr;
		logic              rd;
	} rfd_bus_req_t;

	localparam logic [REG_AW-1:0] REG_STATUS = 4'h0;
	localparam logic [REG_AW-1:0] REG_MASK   = 4'h4;
	localparam logic [REG_AW-1:0] REG_STATE  = 4'h8;

	localparam int EV_W      = 3;
	localparam int EV_ACCEPT = 0;
	localparam int EV_END    = 1;
	localparam int EV_REJECT = 2;

	localparam int STB_VALID    = 0;
	localparam int STB_OSC      = 1;
	localparam int STB_LOWPWR   = 2;
	localparam int STB_DATA_LSB = 8;

	typedef enum {RFD_STANDBY, RFD_HUNT, RFD_CELL} rfd_state_t;

endpackage

`default_nettype wire

/* hdl/rfd_decoder.sv */
/*
 * rfd_decoder: splits the demodulated serial stream into a ten digit tri-state
 * address and eight data bits, checks it against the local match lines and
 * drives momentary decoded outputs, a valid flag, raw data and an interrupt.
 * Assumes all inputs synchronous to i_clk; frames use one rising edge per cell,
 * short high = 0, long high = 1, preceded by a low pilot gap.
 */
`timescale 1ns/1ps
`default_nettype none

module rfd_decoder
(
	input  wire logic                  i_clk,
	input  wire logic                  i_srst,
	input  wire logic                  i_serial_in,
	input  wire logic                  i_power_down_n,
	input  wire rfd_pkg::rfd_match_t   i_match_code_lines,
	input  wire rfd_pkg::rfd_bus_req_t i_bus,
	output logic [31:0]                o_rdata,
	output logic [7:0]                 o_decoded_outputs,
	output logic                       o_valid_flag,
	output logic                       o_raw_data,
	output logic                       o_osc_run,
	output logic                       o_low_power,
	output logic                       o_irq
);
	import rfd_pkg::*;

	// ============================================================
	// declarations
	rfd_state_t              st_ff;
	logic                    ser_d_ff;
	logic [CNT_W-1:0]        low_cnt_ff;
	logic [CNT_W-1:0]        phase_ff;
	logic [IDX_W-1:0]        idx_ff;
	logic [FRAME_CELLS-1:0]  sh_ff;
	logic                    hit_ff;
	logic                    miss_ff;
	logic                    valid_ff;
	logic [DATA_BITS-1:0]    dout_ff;
	logic                    osc_ff;
	logic                    low_power_ff;
	logic                    raw_ff;
	logic [EV_W-1:0]         status_ff;
	logic [EV_W-1:0]         mask_ff;
	logic                    irq_ff;
	logic [31:0]             rdata_ff;
	logic [EV_W-1:0]         nxt_status;
	logic [EV_W-1:0]         ev;
	logic [ADDR_DIGITS-1:0]  digit_hit;
	logic [31:0]             state_word;
	rfd_frame_t              frame;
	logic                    rise;
	logic                    gap_seen;
	logic                    sig_stop;
	logic                    cell_end;
	logic                    sample;
	logic                    frame_done;
	logic                    addr_ok;
	logic                    rd_status;

	function automatic rfd_trit_t pair_to_trit(input logic [1:0] p);
		rfd_trit_t t;
		t = TRIT_BAD;
		case (p)
			PAIR_LOW:   t = TRIT_LOW;
			PAIR_HIGH:  t = TRIT_HIGH;
			PAIR_FLOAT: t = TRIT_FLOAT;
			default:    t = TRIT_BAD;
		endcase
		return t;
	endfunction

	// ============================================================
	// line timing
	assign rise     = i_serial_in && !ser_d_ff;
	assign gap_seen = low_cnt_ff >= GAP_CYC;
	// a frozen low line ends reception; the idle-low sender lets us sleep
	assign sig_stop = (st_ff != RFD_STANDBY) && (low_cnt_ff >= STOP_CYC);
	assign cell_end = (st_ff == RFD_CELL) && (phase_ff == CELL_LAST);
	assign sample   = (st_ff == RFD_CELL) && (phase_ff == SAMPLE_CYC);
	assign frame_done = cell_end && (idx_ff == FRAME_LAST) && !sig_stop && i_power_down_n;

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			ser_d_ff   <= 1'b0;
			low_cnt_ff <= '0;
		end
		else
		begin
			ser_d_ff <= i_serial_in;
			if (i_serial_in)
				low_cnt_ff <= '0;
			else if (low_cnt_ff != STOP_CYC)
				low_cnt_ff <= low_cnt_ff + 1'b1;
		end
	end

	// ============================================================
	// receive sequencer
	always_ff @(posedge i_clk)
	begin
		if (i_srst || !i_power_down_n)
			st_ff <= RFD_STANDBY;
		else
		begin
			case (st_ff)
				RFD_STANDBY:
					if (i_serial_in)
						st_ff <= RFD_HUNT;
				RFD_HUNT:
					if (sig_stop)
						st_ff <= RFD_STANDBY;
					else if (rise && gap_seen)
						st_ff <= RFD_CELL;
				RFD_CELL:
					if (sig_stop)
						st_ff <= RFD_STANDBY;
					else if (cell_end && idx_ff == FRAME_LAST)
						st_ff <= RFD_HUNT;
				default:
					st_ff <= RFD_STANDBY;
			endcase
		end
	end

	// cells are timed from the frame's first edge only; sender drift over a
	// frame must stay under a quarter cell
	always_ff @(posedge i_clk)
	begin
		if (i_srst || st_ff != RFD_CELL)
		begin
			phase_ff <= '0;
			idx_ff   <= '0;
		end
		else if (cell_end)
		begin
			phase_ff <= '0;
			idx_ff   <= idx_ff + 1'b1;
		end
		else
			phase_ff <= phase_ff + 1'b1;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			sh_ff <= '0;
		else if (sample)
			sh_ff <= {sh_ff[FRAME_CELLS-2:0], i_serial_in};
	end

	// ============================================================
	// address compare
	assign frame = rfd_frame_t'(sh_ff);

	genvar g;
	generate
		for (g = 0; g < ADDR_DIGITS; g++)
		begin : g_digit
			// digit 0 is sent first; all three digit states are legal
			assign digit_hit[g] =
				(pair_to_trit(frame.addr_cells[ADDR_CELLS-1-CELLS_PER_DIGIT*g -: 2])
				== i_match_code_lines[g]) && (i_match_code_lines[g] != TRIT_BAD);
		end
	endgenerate

	assign addr_ok = &digit_hit;

	// ============================================================
	// confirmation and outputs
	always_ff @(posedge i_clk)
	begin
		if (i_srst || !i_power_down_n || sig_stop)
		begin
			hit_ff  <= 1'b0;
			miss_ff <= 1'b0;
		end
		else if (frame_done)
		begin
			hit_ff  <= addr_ok;
			miss_ff <= !addr_ok;
		end
	end

	// one stray mismatch is ignored, two in a row end the transmission
	always_ff @(posedge i_clk)
	begin
		if (i_srst || !i_power_down_n || sig_stop)
		begin
			valid_ff <= 1'b0;
			dout_ff  <= '0;
		end
		else if (frame_done)
		begin
			if (addr_ok && hit_ff)
			begin
				valid_ff <= 1'b1;
				dout_ff  <= frame.data;
			end
			else if (!addr_ok && miss_ff)
			begin
				valid_ff <= 1'b0;
				dout_ff  <= '0;
			end
			// a first mismatch leaves the valid flag and outputs as they were
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst || !i_power_down_n)
			osc_ff <= 1'b0;
		else if (st_ff == RFD_STANDBY && i_serial_in)
			osc_ff <= 1'b1;
		else if (sig_stop)
			osc_ff <= 1'b0;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			low_power_ff <= 1'b0;
			raw_ff       <= 1'b0;
		end
		else
		begin
			low_power_ff <= !i_power_down_n;
			raw_ff       <= i_serial_in;
		end
	end

	// ============================================================
	// events and interrupt
	assign ev[EV_ACCEPT] = frame_done && addr_ok && hit_ff && !valid_ff;
	assign ev[EV_END]    = valid_ff && (sig_stop || !i_power_down_n ||
		(frame_done && !addr_ok && miss_ff));
	assign ev[EV_REJECT] = frame_done && !addr_ok;
	assign rd_status     = i_bus.rd && (i_bus.addr == REG_STATUS);
	// set wins over the read clear so no event is lost
	assign nxt_status    = (rd_status ? '0 : status_ff) | ev;

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			status_ff <= '0;
			irq_ff    <= 1'b0;
		end
		else
		begin
			status_ff <= nxt_status;
			irq_ff    <= |(nxt_status & mask_ff);
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			mask_ff <= '0;
		else if (i_bus.wr && i_bus.addr == REG_MASK)
			mask_ff <= i_bus.wdata[EV_W-1:0];
	end

	// ============================================================
	// register read
	always_comb
	begin
		state_word = '0;
		state_word[STB_VALID]  = valid_ff;
		state_word[STB_OSC]    = osc_ff;
		state_word[STB_LOWPWR] = low_power_ff;
		state_word[STB_DATA_LSB +: DATA_BITS] = dout_ff;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst || !i_bus.rd)
			rdata_ff <= '0;
		else
		begin
			case (i_bus.addr)
				REG_STATUS: rdata_ff <= {{(32-EV_W){1'b0}}, status_ff};
				REG_MASK:   rdata_ff <= {{(32-EV_W){1'b0}}, mask_ff};
				REG_STATE:  rdata_ff <= state_word;
				default:    rdata_ff <= '0;
			endcase
		end
	end

	assign o_rdata           = rdata_ff;
	assign o_decoded_outputs = dout_ff;
	assign o_valid_flag      = valid_ff;
	assign o_raw_data        = raw_ff;
	assign o_osc_run         = osc_ff;
	assign o_low_power       = low_power_ff;
	assign o_irq             = irq_ff;

	// ============================================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	pdn_quiet_a: assert property (!i_power_down_n
		|=> !o_valid_flag && o_decoded_outputs == '0)
		else $error("outputs active during power-down");
	pdn_sleep_a: assert property (!i_power_down_n |=> o_low_power && !o_osc_run)
		else $error("power-down did not stop the oscillator");
	pdn_no_rx_a: assert property (!i_power_down_n |=> st_ff == RFD_STANDBY)
		else $error("receiver active during power-down");
	raw_follow_a: assert property (1'b1 |=> o_raw_data == $past(i_serial_in))
		else $error("raw output not following serial input");
	// the flag is a flop, so it drops one edge after power-down is seen
	valid_osc_a: assert property (o_valid_flag |-> o_osc_run && $past(i_power_down_n))
		else $error("valid flag without active reception");
	accept_load_a: assert property (frame_done && addr_ok && hit_ff
		|=> o_valid_flag && o_decoded_outputs == $past(frame.data))
		else $error("confirmed frame not presented");
	single_hit_a: assert property (frame_done && addr_ok && !hit_ff && !o_valid_flag
		|=> !o_valid_flag)
		else $error("accepted on a single frame");
	reject_keep_a: assert property (frame_done && !addr_ok && !miss_ff
		|=> $stable(o_valid_flag) && $stable(o_decoded_outputs))
		else $error("first mismatch changed outputs");
	stop_clear_a: assert property (sig_stop
		|=> !o_valid_flag && o_decoded_outputs == '0)
		else $error("outputs held after signal loss");
	outs_idle_a: assert property (!o_valid_flag |-> o_decoded_outputs == '0)
		else $error("decoded outputs set without valid flag");
	wake_a: assert property (st_ff == RFD_STANDBY && i_power_down_n && i_serial_in
		|=> o_osc_run ##0 st_ff == RFD_HUNT)
		else $error("no wake on serial activity");
	irq_raise_a: assert property ((ev & mask_ff) != '0 |=> o_irq)
		else $error("unmasked event did not raise interrupt");

	accept_c: cover property (ev[EV_ACCEPT]);
	reject_c: cover property (ev[EV_REJECT] ##1 ev[EV_REJECT]);
	stop_c: cover property (o_valid_flag ##1 sig_stop);

endmodule

`default_nettype wire

/* test/rfd_encoder_model.sv */
/*
 * rfd_encoder_model: behavioural far-end sender driving the decoder serial input.
 * Assumes the bench calls its tasks from one process synced to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module rfd_encoder_model
(
	input  wire logic i_clk,
	output var  logic o_serial
);
	import rfd_pkg::*;

	// ============================================================
	// line coding
	initial o_serial = 1'b0;

	task automatic set_level(input logic v);
		@(posedge i_clk);
		o_serial <= v;
	endtask

	// short high is 0, long high is 1; both clear the mid-cell sample point
	task automatic send_cell(input logic b);
		int hi;
		hi = b ? int'(CELL_CYC) * 3 / 4 : int'(CELL_CYC) / 4;
		o_serial <= 1'b1;
		repeat (hi) @(posedge i_clk);
		o_serial <= 1'b0;
		repeat (int'(CELL_CYC) - hi) @(posedge i_clk);
	endtask

	task automatic send_frame(input rfd_match_t a, input logic [7:0] d);
		logic [1:0] p;
		@(posedge i_clk);
		o_serial <= 1'b0;
		repeat (int'(GAP_CYC) + 10) @(posedge i_clk);
		for (int g = 0; g < ADDR_DIGITS; g++)
		begin
			p = (a[g] == TRIT_HIGH) ? PAIR_HIGH :
				(a[g] == TRIT_FLOAT) ? PAIR_FLOAT : PAIR_LOW;
			send_cell(p[1]);
			send_cell(p[0]);
		end
		for (int i = DATA_BITS - 1; i >= 0; i--)
			send_cell(d[i]);
	endtask
endmodule

`default_nettype wire

/* test/tb.sv */
/*
 * tb: self-checking bench for rfd_decoder fed by the sender model.
 * Assumes rfd_pkg, rfd_decoder and rfd_encoder_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
	import rfd_pkg::*;
	localparam rfd_match_t ADDR = {TRIT_FLOAT, TRIT_HIGH, TRIT_LOW, TRIT_FLOAT, TRIT_HIGH,
		TRIT_LOW, TRIT_FLOAT, TRIT_HIGH, TRIT_LOW, TRIT_FLOAT};
	logic         i_clk;
	logic         i_srst;
	logic         i_power_down_n;
	logic         serial;
	rfd_match_t   match_lines;
	rfd_bus_req_t bus;
	logic [31:0]  rdata;
	logic [7:0]   dout;
	logic         valid;
	logic         raw;
	logic         osc;
	logic         lowp;
	logic         irq;
	int           failures = 0;
	int           n_tests = 0;

	rfd_encoder_model enc (.i_clk(i_clk), .o_serial(serial));
	rfd_decoder uut (.i_clk(i_clk), .i_srst(i_srst), .i_serial_in(serial),
		.i_power_down_n(i_power_down_n), .i_match_code_lines(match_lines), .i_bus(bus),
		.o_rdata(rdata), .o_decoded_outputs(dout), .o_valid_flag(valid),
		.o_raw_data(raw), .o_osc_run(osc), .o_low_power(lowp), .o_irq(irq));

	// ============================================================
	// helpers
	function automatic logic [31:0] pins();
		return {19'h0, raw, irq, lowp, osc, valid, dout};
	endfunction

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		bus.wr <= 1'b0;
	endtask

	task automatic bus_rd(input string name, input logic [3:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge i_clk);
		bus.rd <= 1'b0;
		#1;
		chk(name, exp, rdata);
	endtask

	task automatic conclude;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ============================================================
	// scenarios
	task automatic t_reset;
		chk("pins", 32'h0, pins());
		bus_rd("mask", REG_MASK, 32'h0);
	endtask

	task automatic t_powerdown;
		@(posedge i_clk);
		i_power_down_n <= 1'b0;
		enc.set_level(1'b1);
		wait_cyc(3);
		chk("pins", 32'h1400, pins());
		enc.set_level(1'b0);
		@(posedge i_clk);
		i_power_down_n <= 1'b1;
		wait_cyc(3);
		chk("pins", 32'h0, pins());
	endtask

	// one good frame only primes the comparison
	task automatic t_prime;
		bus_wr(REG_MASK, 32'h1);
		enc.set_level(1'b1);
		wait_cyc(10);
		enc.set_level(1'b0);
		enc.send_frame(ADDR, 8'hA5);
		wait_cyc(5);
		chk("pins", 32'h0200, pins());
	endtask

	task automatic t_accept;
		enc.send_frame(ADDR, 8'h3C);
		wait_cyc(5);
		chk("pins", 32'h0B3C, pins());
		bus_rd("state", REG_STATE, 32'h3C03);
		bus_rd("status", REG_STATUS, 32'h1);
		bus_rd("status", REG_STATUS, 32'h0);
		bus_rd("mask", REG_MASK, 32'h1);
		bus_rd("unmapped", 4'hC, 32'h0);
		chk("pins", 32'h033C, pins());
	endtask

	task automatic t_mismatch;
		rfd_match_t bad;
		bad = ADDR;
		bad[0] = TRIT_HIGH;
		enc.send_frame(bad, 8'hFF);
		wait_cyc(5);
		chk("pins", 32'h033C, pins());
		bus_rd("status", REG_STATUS, 32'h4);
	endtask

	task automatic t_release;
		wait_cyc(1000);
		chk("pins", 32'h033C, pins());
		@(posedge i_clk);
		i_power_down_n <= 1'b0;
		wait_cyc(3);
		chk("pins", 32'h0400, pins());
		bus_rd("status", REG_STATUS, 32'h2);
		bus_rd("state", REG_STATE, 32'h4);
	endtask

	// a wake-up with no frame after it: the stop timeout must put the block back to sleep
	task automatic t_stop;
		@(posedge i_clk);
		i_power_down_n <= 1'b1;
		enc.set_level(1'b1);
		wait_cyc(3);
		chk("pins", 32'h1200, pins());
		enc.set_level(1'b0);
		wait_cyc(int'(STOP_CYC) - 10);
		chk("pins", 32'h0200, pins());
		wait_cyc(12);
		chk("pins", 32'h0, pins());
		bus_rd("status", REG_STATUS, 32'h0);
	endtask

	// ============================================================
	// clock, watchdog and main sequence
	initial
	begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	// three frames of about 31k cycles and one stop wait end near 98k cycles
	initial
	begin
		#9_950_000;
		failures++;
		conclude();
	end

	initial
	begin
		i_srst = 1'b1;
		i_power_down_n = 1'b1;
		match_lines = ADDR;
		bus = '0;
		repeat (6) @(posedge i_clk);
		i_srst <= 1'b0;
		wait_cyc(2);
		t_reset();
		t_powerdown();
		t_prime();
		t_accept();
		t_mismatch();
		t_release();
		t_stop();
		conclude();
	end
endmodule

`default_nettype wire
